//--- rtl/eps_status.sv
// Purpose: Status indicators and reconfiguration port of a multi-rate PHY
// Assumes: Core status inputs are synchronous to clk_sys
// Notes: Indicator outputs are registered, one cycle behind their sources
`timescale 1ns/100ps
// Operation
// - Data-lock indicator high while recovery loop is locked to receive data.
// - Transmit calibration busy stays high for whole transmit calibration.
// - Receive calibration busy stays high for whole receive calibration.
// - Reconfiguration port: own clock and reset, 11-bit address, 32-bit data.
// - Character error flags invalid code groups at 1G and 2.5G only.
// - Without negotiation, panel link shows link synchronization success at 1G and 2.5G only.
// - Block lock reported for 10G MGBASE-T and every USXGMII speed.
// - Transmit and receive latency values are passed to the MAC.
module eps_status #(
  parameter int AW = eps_pkg::RCFG_ADDR_W,
  parameter int DW = eps_pkg::RCFG_DATA_W,
  parameter int LW = eps_pkg::LAT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire eps_pkg::eps_mode_t mode,
  input wire eps_pkg::eps_speed_t speed,
  input wire logic cdr_locked,
  input wire logic tx_cal_run,
  input wire logic rx_cal_run,
  input wire logic code_invalid,
  input wire logic disp_invalid,
  input wire logic link_sync_ok,
  input wire logic an_complete,
  input wire logic block_sync_ok,
  input wire logic [LW-1:0] tx_lat_in,
  input wire logic [LW-1:0] rx_lat_in,
  output logic rx_data_lock_ind,
  output logic tx_cal_busy,
  output logic rx_cal_busy,
  output logic char_err_ind,
  output logic disp_err_ind,
  output logic link_ind,
  output logic autoneg_done_ind,
  output logic panel_link_ind,
  output logic block_lock_ind,
  output logic [LW-1:0] tx_latency,
  output logic [LW-1:0] rx_latency,
  input wire logic reconfig_clk,
  input wire logic reconfig_reset,
  input wire logic [AW-1:0] reconfig_address,
  input wire logic reconfig_write,
  input wire logic reconfig_read,
  input wire logic [DW-1:0] reconfig_writedata,
  output logic [DW-1:0] reconfig_readdata,
  output logic reconfig_waitrequest
);
  initial
  begin
    if (AW < 1 || AW > 16 || DW < 1 || LW < 1 ||
      eps_pkg::RCFG_WAIT_CYC == 2'h0 || eps_pkg::RCFG_WAIT_CYC == 2'h3)
    begin
      $error("eps_status: unsupported parameter values");
    end
  end

  function automatic logic is_8b10b(input eps_pkg::eps_speed_t s);
    is_8b10b = (s == eps_pkg::EPS_SPD_1G) || (s == eps_pkg::EPS_SPD_2G5);
  endfunction

  function automatic logic uses_an(input eps_pkg::eps_mode_t m);
    uses_an = (m == eps_pkg::EPS_MODE_BASEX_AN) || (m == eps_pkg::EPS_MODE_SGMII_MAC_AN);
  endfunction

  function automatic logic is_10g(input eps_pkg::eps_speed_t s);
    is_10g = (s == eps_pkg::EPS_SPD_10G);
  endfunction

  logic block_ok_d;
  logic panel_d;

  // Block lock only in the block-coded modes
  always_comb
  begin
    block_ok_d = 1'b0;
    case (mode)
      eps_pkg::EPS_MODE_MGBASET: block_ok_d = block_sync_ok && is_10g(speed);
      eps_pkg::EPS_MODE_USXGMII: block_ok_d = block_sync_ok;
      default: block_ok_d = 1'b0;
    endcase
  end

  // Panel link source follows the negotiation mode
  always_comb
  begin
    if (uses_an(mode))
    begin
      panel_d = an_complete;
    end
    else if (is_8b10b(speed))
    begin
      panel_d = link_sync_ok;
    end
    else
    begin
      panel_d = 1'b0;
    end
  end

  // Transceiver status
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_data_lock_ind <= 1'b0;
      tx_cal_busy <= 1'b0;
      rx_cal_busy <= 1'b0;
    end
    else
    begin
      rx_data_lock_ind <= cdr_locked;
      tx_cal_busy <= tx_cal_run;
      rx_cal_busy <= rx_cal_run;
    end
  end

  // PCS link status
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      char_err_ind <= 1'b0;
      disp_err_ind <= 1'b0;
      link_ind <= 1'b0;
      autoneg_done_ind <= 1'b0;
      panel_link_ind <= 1'b0;
      block_lock_ind <= 1'b0;
    end
    else
    begin
      char_err_ind <= code_invalid && is_8b10b(speed);
      disp_err_ind <= disp_invalid && is_8b10b(speed);
      link_ind <= link_sync_ok && is_8b10b(speed);
      autoneg_done_ind <= an_complete && !is_10g(speed);
      panel_link_ind <= panel_d;
      block_lock_ind <= block_ok_d;
    end
  end

  // Latency to MAC
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_latency <= '0;
      rx_latency <= '0;
    end
    else
    begin
      tx_latency <= tx_lat_in;
      rx_latency <= rx_lat_in;
    end
  end

  // Reconfiguration port, timed by reconfig_clk
  logic [1:0] rd_cnt_q;
  logic [1:0] rd_cnt_d;
  logic rd_load;
  logic rd_ready;
  logic [DW-1:0] mem_rdata;
  logic mem_we;

  assign mem_we = reconfig_write && !reconfig_reset;

  eps_rcfg_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk_sys(reconfig_clk),
    .we(mem_we),
    .addr(reconfig_address),
    .wdata(reconfig_writedata),
    .rdata_q(mem_rdata)
  );

  // Store answers after its latency; the read data register needs one cycle more
  assign rd_load = reconfig_read && (rd_cnt_q == eps_pkg::RCFG_WAIT_CYC);
  assign rd_ready = reconfig_read && (rd_cnt_q == 2'(eps_pkg::RCFG_WAIT_CYC + 2'h1));

  always_comb
  begin
    rd_cnt_d = rd_cnt_q;
    if (!reconfig_read || rd_ready)
    begin
      rd_cnt_d = 2'h0;
    end
    else
    begin
      rd_cnt_d = 2'(rd_cnt_q + 2'h1);
    end
  end

  always_ff @(posedge reconfig_clk)
  begin
    if (reconfig_reset)
    begin
      rd_cnt_q <= 2'h0;
    end
    else
    begin
      rd_cnt_q <= rd_cnt_d;
    end
  end

  always_ff @(posedge reconfig_clk)
  begin
    if (reconfig_reset)
    begin
      reconfig_readdata <= DW'(eps_pkg::RCFG_RESET_VAL);
    end
    else if (rd_load)
    begin
      reconfig_readdata <= mem_rdata;
    end
  end

  // Reads stall until the word stands in the read data register; writes wait only while reconfig_reset is high
  assign reconfig_waitrequest = reconfig_reset || (reconfig_read && !rd_ready);
endmodule

//--- inc/eps_pkg.sv
// Purpose: Shared constants for the PHY status and reconfiguration layer
// Assumes: Two clock domains, clk_sys and reconfig_clk, synchronous active-high resets
// Notes: Modes select which source drives the panel link indicator
package eps_pkg;
  localparam int RCFG_ADDR_W = 11;
  localparam int RCFG_DATA_W = 32;
  localparam int LAT_W = 24;
  localparam logic [31:0] RCFG_RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] RCFG_WAIT_CYC = 2'h1;

  typedef enum logic [2:0] {
    EPS_MODE_BASEX_NOAN,
    EPS_MODE_SGMII_NOAN,
    EPS_MODE_BASEX_AN,
    EPS_MODE_SGMII_MAC_AN,
    EPS_MODE_MGBASET,
    EPS_MODE_USXGMII
  } eps_mode_t;

  typedef enum logic [1:0] {
    EPS_SPD_1G,
    EPS_SPD_2G5,
    EPS_SPD_5G,
    EPS_SPD_10G
  } eps_speed_t;
endpackage

//--- rtl/eps_rcfg_mem.sv
// Purpose: Word store behind the reconfiguration port
// Assumes: Single port, registered read data
// Notes: Read data appear one cycle after the address
`timescale 1ns/100ps
module eps_rcfg_mem #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rdata_q <= mem[addr];
  end
endmodule

//--- sim/eps_status_chk.sv
// Purpose: Status port assertions
// Assumes: Status on clk_sys, port on reconfig_clk
// Notes: Bound by name
`timescale 1ns/100ps
module eps_status_chk (
  input logic clk_sys,
  input logic rst,
  input eps_pkg::eps_mode_t mode,
  input eps_pkg::eps_speed_t speed,
  input logic cdr_locked,
  input logic tx_cal_run,
  input logic rx_cal_run,
  input logic code_invalid,
  input logic link_sync_ok,
  input logic an_complete,
  input logic block_sync_ok,
  input logic rx_data_lock_ind,
  input logic tx_cal_busy,
  input logic rx_cal_busy,
  input logic char_err_ind,
  input logic link_ind,
  input logic panel_link_ind,
  input logic block_lock_ind,
  input logic reconfig_clk,
  input logic reconfig_reset,
  input logic reconfig_read,
  input logic reconfig_waitrequest
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_lock_on: assert property (cdr_locked |=> rx_data_lock_ind) else $error("on");
  chk_lock_off: assert property (!cdr_locked |=> !rx_data_lock_ind) else $error("off");
  chk_char_gate: assert property (
    code_invalid && speed == 2'h3 |=> !char_err_ind) else $error("c10");
  chk_char_flag: assert property (
    code_invalid && speed == 2'h0 |=> char_err_ind) else $error("c1");
  chk_panel_an: assert property (
    mode == 3'h3 |=> panel_link_ind == $past(an_complete)) else $error("an");
  chk_blk_off: assert property (mode == 3'h1 |=> !block_lock_ind) else $error("b1");
  chk_blk_speed: assert property (
    mode == 3'h4 && speed != 2'h3 |=> !block_lock_ind) else $error("b4");
  chk_txcal_busy: assert property (tx_cal_run |=> tx_cal_busy) else $error("txcal");
  chk_rxcal_busy: assert property (rx_cal_run |=> rx_cal_busy) else $error("rxcal");
  chk_panel_sync: assert property (
    mode == eps_pkg::EPS_MODE_SGMII_NOAN && speed == eps_pkg::EPS_SPD_2G5 && link_sync_ok
    |=> panel_link_ind) else $error("panel sync");
  chk_link_sync: assert property (
    link_sync_ok && speed == eps_pkg::EPS_SPD_2G5 |=> link_ind) else $error("link");
  chk_blk_usx: assert property (
    mode == eps_pkg::EPS_MODE_USXGMII && block_sync_ok |=> block_lock_ind) else $error("b5");
  chk_rd_wait: assert property (@(posedge reconfig_clk) disable iff (reconfig_reset)
    $rose(reconfig_read) |-> reconfig_waitrequest ##1 reconfig_waitrequest
    ##1 !reconfig_waitrequest) else $error("w");
  cover property (block_lock_ind);
  cover property (panel_link_ind);
  cover property (@(posedge reconfig_clk) disable iff (reconfig_reset)
    reconfig_read && !reconfig_waitrequest);
endmodule
bind eps_status eps_status_chk u_chk (.*);

//--- sim/eps_rcfg_host.sv
// Purpose: Reconfiguration block model
// Assumes: Shares clk_sys
// Notes: Request held until wait drops
`timescale 1ns/100ps
module eps_rcfg_host (
  input logic clk_sys,
  input logic [31:0] rdat,
  input logic wt,
  output logic [10:0] ra,
  output logic rw,
  output logic rr,
  output logic [31:0] wd
);
  initial {ra, rw, rr, wd} = '0;
  task automatic xfer(input logic w, input logic [10:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    ra <= a;
    wd <= d;
    rw <= w;
    rr <= !w;
    do @(posedge clk_sys); while (wt);
    q = rdat;
    rw <= 1'b0;
    rr <= 1'b0;
    wd <= ~d;
  endtask
endmodule

//--- sim/eps_status_tb.sv
// Purpose: Bench for eps_status
// Assumes: Reconfig on clk_sys
// Notes: Row table, then edge cases
`timescale 1ns/100ps
module eps_status_tb;
  logic clk_sys, rst;
  logic [2:0] md;
  logic [1:0] sp;
  logic [7:0] s;
  logic [23:0] lat;
  logic [31:0] q;
  wire [8:0] o;
  wire [47:0] lo;
  wire [31:0] rdat, wd;
  wire [10:0] ra;
  wire rw, rr, wt;
  int failures, cmp_count;
  logic [21:0] rows [8] = '{{3'h0, 2'h0, 8'hff, 9'h1fe}, {3'h2, 2'h3, 8'hff, 9'h1c2},
    {3'h4, 2'h3, 8'hff, 9'h1c1}, {3'h4, 2'h2, 8'hff, 9'h1c4}, {3'h5, 2'h2, 8'hff, 9'h1c5},
    {3'h3, 2'h1, 8'h04, 9'h008}, {3'h1, 2'h1, 8'h0d, 9'h01a}, {3'h1, 2'h0, 8'h90, 9'h120}};
  eps_status u_eps_status (.clk_sys, .rst, .mode(eps_pkg::eps_mode_t'(md)),
    .speed(eps_pkg::eps_speed_t'(sp)), .cdr_locked(s[7]), .tx_cal_run(s[6]), .rx_cal_run(s[5]),
    .code_invalid(s[4]), .disp_invalid(s[3]), .link_sync_ok(s[2]), .an_complete(s[1]),
    .block_sync_ok(s[0]), .tx_lat_in(lat), .rx_lat_in(~lat), .rx_data_lock_ind(o[8]),
    .tx_cal_busy(o[7]), .rx_cal_busy(o[6]), .char_err_ind(o[5]), .disp_err_ind(o[4]),
    .link_ind(o[3]), .autoneg_done_ind(o[2]), .panel_link_ind(o[1]), .block_lock_ind(o[0]),
    .tx_latency(lo[47:24]), .rx_latency(lo[23:0]), .reconfig_clk(clk_sys), .reconfig_reset(rst),
    .reconfig_address(ra), .reconfig_write(rw), .reconfig_read(rr), .reconfig_writedata(wd),
    .reconfig_readdata(rdat), .reconfig_waitrequest(wt));
  eps_rcfg_host u_eps_rcfg_host (.*);
  task chk(input logic [47:0] g, e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task print_verdict;
    $display("%0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #20000;
    failures++;
    print_verdict;
  end
  initial
  begin
    {rst, md, sp, s, lat} = {1'b1, 37'h0};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      {md, sp, s} <= rows[i][21:9];
      lat <= 24'h5a5a00 ^ 24'(i);
      @(posedge clk_sys);
      #1;
      chk(48'(o), 48'(rows[i][8:0]), "st");
      chk(lo, {lat, ~lat}, "lat");
    end
    $display("rows done");
    u_eps_rcfg_host.xfer(1'b1, 11'h7ff, 32'hdeadbeef, q);
    u_eps_rcfg_host.xfer(1'b1, 11'h000, 32'h12345678, q);
    u_eps_rcfg_host.xfer(1'b0, 11'h7ff, 32'h0, q);
    chk(48'(q), 48'hdeadbeef, "rd top");
    u_eps_rcfg_host.xfer(1'b0, 11'h000, 32'h0, q);
    chk(48'(q), 48'h12345678, "rd low");
    $display("reconfig done");
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1 chk(48'({o, wt, rdat}), 48'h100000000, "in reset");
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk(48'(o[8]), 48'h1, "release");
    $display("reset done");
    print_verdict;
  end
endmodule
